// file: rtl/pmc_pkg.sv
// Constants and types for the privilege and mode control block.
// Assumes a single core clock and a synchronous reset.
package pmc_pkg;

  // ----------------------------------------------------------------
  // Widths and control bit positions
  // ----------------------------------------------------------------
  localparam int unsigned PMC_XLEN      = 32;
  localparam int unsigned PMC_CTRL_W    = 2;
  localparam int unsigned PMC_CTRL_NPRV = 0;
  localparam int unsigned PMC_CTRL_SPS  = 1;
  localparam int unsigned PMC_ENC_W     = 32;
  localparam int unsigned PMC_HW_W      = 16;

  // ----------------------------------------------------------------
  // Encoding and address constants
  // ----------------------------------------------------------------
  localparam logic [1:0]  PMC_CTRL_RST   = 2'h0;
  localparam logic [4:0]  PMC_WIDE_PFX   = 5'h1d;
  localparam logic [1:0]  PMC_WIDE_MASK  = 2'h3;
  localparam logic [31:0] PMC_RST_SP     = 32'h0000_0000;
  localparam logic [31:0] PMC_SP_ALIGN   = 32'hffff_fffc;
  localparam logic [31:0] PMC_SRAM_BASE  = 32'h2000_0000;
  localparam logic [31:0] PMC_SRAM_END   = 32'h200f_ffff;
  localparam logic [31:0] PMC_BB_BASE    = 32'h2200_0000;
  localparam logic [31:0] PMC_BB_END     = 32'h23ff_ffff;
  localparam int unsigned PMC_BB_SHIFT   = 5;
  localparam int unsigned PMC_BB_BITSEL  = 2;

  // ----------------------------------------------------------------
  // Execution states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PMC_PRV_THREAD = 3'b001,
    PMC_USR_THREAD = 3'b010,
    PMC_PRV_HANDLR = 3'b100
  } pmc_state_e;

endpackage

// file: rtl/pmc_core.sv
// Privilege level, thread/handler mode and stack pointer banking.
// Assumes decode and exception control on mclk drive the request inputs.
`timescale 1ns/100ps

module pmc_core import pmc_pkg::*; #(
  parameter int unsigned XLEN = PMC_XLEN
) (
  input  wire logic            mclk,
  input  wire logic            srst,
  input  wire logic            exc_entry,
  input  wire logic            exc_return,
  input  wire logic            ctrl_we,
  input  wire logic [1:0]      ctrl_wdata,
  input  wire logic            sp_we,
  input  wire logic [XLEN-1:0] sp_wdata,
  input  wire logic            restricted_req,
  input  wire logic [31:0]     instr_word,
  input  wire logic            mem_req,
  input  wire logic [31:0]     mem_addr,
  output logic                 handler_mode_r,
  output logic                 user_level_r,
  output logic                 use_psp_r,
  output logic [1:0]           ctrl_r,
  output logic [XLEN-1:0]      main_stack_pointer_r,
  output logic [XLEN-1:0]      process_stack_pointer_r,
  output logic [XLEN-1:0]      sp_active_r,
  output logic                 access_fault_r,
  output logic                 instr_wide_r,
  output logic                 bb_hit_r,
  output logic [31:0]          bb_word_addr_r,
  output logic [4:0]           bb_bit_r
);

  // ----------------------------------------------------------------
  // Execution state
  // ----------------------------------------------------------------
  pmc_state_e state_r;
  pmc_state_e state_nxt;
  logic [1:0] ctrl_nxt;
  logic       ctrl_wr_ok;
  logic       thread_user_nxt;

  // Next thread level, kept apart from ctrl_nxt to avoid a loop
  assign ctrl_wr_ok      = ctrl_we && (state_r != PMC_USR_THREAD);
  assign thread_user_nxt = ctrl_wr_ok ? ctrl_wdata[PMC_CTRL_NPRV] : ctrl_r[PMC_CTRL_NPRV];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PMC_PRV_THREAD: begin
        if (exc_entry) begin
          state_nxt = PMC_PRV_HANDLR;
        end else if (thread_user_nxt) begin
          state_nxt = PMC_USR_THREAD;
        end
      end
      PMC_USR_THREAD: begin
        if (exc_entry) begin
          state_nxt = PMC_PRV_HANDLR;
        end
      end
      PMC_PRV_HANDLR: begin
        if (exc_return && !exc_entry) begin
          state_nxt = thread_user_nxt ? PMC_USR_THREAD : PMC_PRV_THREAD;
        end
      end
      default: state_nxt = PMC_PRV_THREAD;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= PMC_PRV_THREAD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr_ok) begin
      ctrl_nxt = ctrl_wdata;
    end
    if (state_nxt == PMC_PRV_HANDLR) begin
      ctrl_nxt[PMC_CTRL_SPS] = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_r <= PMC_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      handler_mode_r <= 1'b0;
      user_level_r   <= 1'b0;
      use_psp_r      <= 1'b0;
    end else begin
      handler_mode_r <= (state_nxt == PMC_PRV_HANDLR);
      user_level_r   <= (state_nxt == PMC_USR_THREAD);
      use_psp_r      <= (state_nxt == PMC_USR_THREAD) && ctrl_nxt[PMC_CTRL_SPS];
    end
  end

  // ----------------------------------------------------------------
  // Banked stack pointers
  // ----------------------------------------------------------------
  logic            psp_sel;
  logic            psp_sel_nxt;
  logic [XLEN-1:0] msp_nxt;
  logic [XLEN-1:0] psp_nxt;
  assign psp_sel     = (state_r == PMC_USR_THREAD) && ctrl_r[PMC_CTRL_SPS];
  assign psp_sel_nxt = (state_nxt == PMC_USR_THREAD) && ctrl_nxt[PMC_CTRL_SPS];

  // Write goes to the bank in use now
  always_comb begin
    msp_nxt = main_stack_pointer_r;
    psp_nxt = process_stack_pointer_r;
    if (sp_we) begin
      if (psp_sel) begin
        psp_nxt = sp_wdata & XLEN'(PMC_SP_ALIGN);
      end else begin
        msp_nxt = sp_wdata & XLEN'(PMC_SP_ALIGN);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      main_stack_pointer_r    <= XLEN'(PMC_RST_SP);
      process_stack_pointer_r <= XLEN'(PMC_RST_SP);
    end else begin
      main_stack_pointer_r    <= msp_nxt;
      process_stack_pointer_r <= psp_nxt;
    end
  end

  // Follows the bank picked by the next state
  always_ff @(posedge mclk) begin
    if (srst) begin
      sp_active_r <= XLEN'(PMC_RST_SP);
    end else begin
      sp_active_r <= psp_sel_nxt ? psp_nxt : msp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Access fault
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      access_fault_r <= 1'b0;
    end else begin
      access_fault_r <= (restricted_req || ctrl_we) && (state_r == PMC_USR_THREAD);
    end
  end

  // ----------------------------------------------------------------
  // Instruction width and bit-band decode
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      instr_wide_r <= 1'b0;
    end else begin
      instr_wide_r <= (instr_word[PMC_HW_W-1 -: 5] == PMC_WIDE_PFX) ||
                      (instr_word[PMC_HW_W-1 -: 4] == {PMC_WIDE_MASK, PMC_WIDE_MASK});
    end
  end

  logic        bb_in;
  logic [31:0] bb_off;
  assign bb_in  = mem_req && (mem_addr >= PMC_BB_BASE) && (mem_addr <= PMC_BB_END);
  assign bb_off = mem_addr - PMC_BB_BASE;

  always_ff @(posedge mclk) begin
    if (srst) begin
      bb_hit_r       <= 1'b0;
      bb_word_addr_r <= PMC_SRAM_BASE;
      bb_bit_r       <= 5'h00;
    end else begin
      bb_hit_r <= bb_in;
      if (bb_in) begin
        bb_word_addr_r <= PMC_SRAM_BASE + ((bb_off >> PMC_BB_SHIFT) & PMC_SP_ALIGN);
        bb_bit_r       <= bb_off[PMC_BB_BITSEL +: $bits(bb_bit_r)];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_user_handler: assert property (@(posedge mclk) disable iff (srst)
    !(handler_mode_r && user_level_r)) else $error("User level in handler mode");
  a_user_fault: assert property (@(posedge mclk) disable iff (srst)
    (restricted_req && state_r == PMC_USR_THREAD) |=> access_fault_r) else $error("No fault at user level");
  a_priv_no_fault: assert property (@(posedge mclk) disable iff (srst)
    (state_r != PMC_USR_THREAD) |=> !access_fault_r) else $error("Fault while privileged");
  a_exc_handler: assert property (@(posedge mclk) disable iff (srst)
    exc_entry |=> handler_mode_r && !user_level_r) else $error("Exception not in handler");
  a_psp_user_only: assert property (@(posedge mclk) disable iff (srst)
    use_psp_r |-> user_level_r && ctrl_r[PMC_CTRL_SPS]) else $error("Process stack outside user thread");
  a_handler_sps: assert property (@(posedge mclk) disable iff (srst)
    handler_mode_r |-> !ctrl_r[PMC_CTRL_SPS]) else $error("Stack select set in handler");
  a_ctrl_user: assert property (@(posedge mclk) disable iff (srst)
    (state_r == PMC_USR_THREAD && !exc_entry) |=> $stable(ctrl_r)) else $error("User changed control");
  a_reset_state: assert property (@(posedge mclk)
    srst |=> !handler_mode_r && !user_level_r && !use_psp_r && ctrl_r == PMC_CTRL_RST)
    else $error("Bad reset state");
  a_bb_hit: assert property (@(posedge mclk) disable iff (srst)
    bb_in |=> bb_hit_r && bb_word_addr_r >= PMC_SRAM_BASE && bb_word_addr_r <= PMC_SRAM_END)
    else $error("Bit-band miss");
  a_sp_active: assert property (@(posedge mclk) disable iff (srst)
    sp_active_r == (use_psp_r ? process_stack_pointer_r : main_stack_pointer_r))
    else $error("Active stack mismatch");

endmodule

// file: bench/tb_top.sv
// Self-checking bench for the privilege and mode control block.
// Assumes pmc_pkg and pmc_core are compiled first; inputs change on falling edges.
`timescale 1ns/100ps

module tb_top import pmc_pkg::*;;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        mclk = 1'b0, srst = 1'b1, exc_entry = 1'b0, exc_return = 1'b0;
  logic        ctrl_we = 1'b0, sp_we = 1'b0, restricted_req = 1'b0, mem_req = 1'b0;
  logic [1:0]  ctrl_wdata = 2'h0;
  logic [31:0] sp_wdata = 32'h0, instr_word = 32'h0, mem_addr = 32'h0;
  logic        handler_mode_r, user_level_r, use_psp_r, access_fault_r, instr_wide_r, bb_hit_r;
  logic [1:0]  ctrl_r;
  logic [31:0] main_stack_pointer_r, process_stack_pointer_r, sp_active_r, bb_word_addr_r;
  logic [4:0]  bb_bit_r;
  int          bad_count = 0;
  int          n_checks = 0;

  always #5 mclk = ~mclk;

  pmc_core dut (.mclk(mclk), .srst(srst), .exc_entry(exc_entry), .exc_return(exc_return),
    .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .sp_we(sp_we), .sp_wdata(sp_wdata),
    .restricted_req(restricted_req), .instr_word(instr_word), .mem_req(mem_req),
    .mem_addr(mem_addr), .handler_mode_r(handler_mode_r), .user_level_r(user_level_r),
    .use_psp_r(use_psp_r), .ctrl_r(ctrl_r), .main_stack_pointer_r(main_stack_pointer_r),
    .process_stack_pointer_r(process_stack_pointer_r), .sp_active_r(sp_active_r),
    .access_fault_r(access_fault_r), .instr_wide_r(instr_wide_r), .bb_hit_r(bb_hit_r),
    .bb_word_addr_r(bb_word_addr_r), .bb_bit_r(bb_bit_r));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic mode(input logic h, input logic u, input logic p, input logic [1:0] c);
    chk("handler_mode_r", {31'h0, h}, {31'h0, handler_mode_r});
    chk("user_level_r", {31'h0, u}, {31'h0, user_level_r});
    chk("use_psp_r", {31'h0, p}, {31'h0, use_psp_r});
    chk("ctrl_r", {30'h0, c}, {30'h0, ctrl_r});
  endtask

  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    mode(1'b0, 1'b0, 1'b0, 2'h0);
    chk("main_stack_pointer_r", 32'h0, main_stack_pointer_r);
    chk("process_stack_pointer_r", 32'h0, process_stack_pointer_r);
    chk("sp_active_r", 32'h0, sp_active_r);
    chk("access_fault_r", 32'h0, {31'h0, access_fault_r});
    chk("bb_hit_r", 32'h0, {31'h0, bb_hit_r});
    chk("bb_word_addr_r", 32'h2000_0000, bb_word_addr_r);
  endtask

  task automatic t_user();
    ctrl_we = 1'b1;
    ctrl_wdata = 2'h3;
    @(negedge mclk);
    ctrl_we = 1'b0;
    mode(1'b0, 1'b1, 1'b1, 2'h3);
    chk("access_fault_r", 32'h0, {31'h0, access_fault_r});
    sp_we = 1'b1;
    sp_wdata = 32'h1234_567b;
    @(negedge mclk);
    sp_we = 1'b0;
    chk("process_stack_pointer_r", 32'h1234_5678, process_stack_pointer_r);
    chk("sp_active_r", 32'h1234_5678, sp_active_r);
    @(negedge mclk);
    chk("sp_active_r", 32'h1234_5678, sp_active_r);
    chk("main_stack_pointer_r", 32'h0, main_stack_pointer_r);
  endtask

  task automatic t_fault();
    restricted_req = 1'b1;
    @(negedge mclk);
    restricted_req = 1'b0;
    chk("access_fault_r", 32'h1, {31'h0, access_fault_r});
    ctrl_we = 1'b1;
    ctrl_wdata = 2'h0;
    @(negedge mclk);
    ctrl_we = 1'b0;
    chk("access_fault_r", 32'h1, {31'h0, access_fault_r});
    mode(1'b0, 1'b1, 1'b1, 2'h3);
    @(negedge mclk);
    chk("access_fault_r", 32'h0, {31'h0, access_fault_r});
  endtask

  task automatic t_exc();
    exc_entry = 1'b1;
    exc_return = 1'b1;
    @(negedge mclk);
    exc_entry = 1'b0;
    exc_return = 1'b0;
    mode(1'b1, 1'b0, 1'b0, 2'h1);
    chk("sp_active_r", 32'h0, sp_active_r);
    restricted_req = 1'b1;
    sp_we = 1'b1;
    sp_wdata = 32'haaaa_0003;
    @(negedge mclk);
    restricted_req = 1'b0;
    sp_we = 1'b0;
    chk("access_fault_r", 32'h0, {31'h0, access_fault_r});
    chk("main_stack_pointer_r", 32'haaaa_0000, main_stack_pointer_r);
    chk("process_stack_pointer_r", 32'h1234_5678, process_stack_pointer_r);
    exc_return = 1'b1;
    @(negedge mclk);
    exc_return = 1'b0;
    mode(1'b0, 1'b1, 1'b0, 2'h1);
    chk("sp_active_r", 32'haaaa_0000, sp_active_r);
  endtask

  task automatic t_nest();
    exc_entry = 1'b1;
    @(negedge mclk);
    exc_entry = 1'b0;
    ctrl_we = 1'b1;
    ctrl_wdata = 2'h2;
    restricted_req = 1'b1;
    @(negedge mclk);
    ctrl_we = 1'b0;
    restricted_req = 1'b0;
    mode(1'b1, 1'b0, 1'b0, 2'h0);
    chk("access_fault_r", 32'h0, {31'h0, access_fault_r});
    exc_entry = 1'b1;
    exc_return = 1'b1;
    @(negedge mclk);
    exc_entry = 1'b0;
    exc_return = 1'b0;
    mode(1'b1, 1'b0, 1'b0, 2'h0);
    exc_return = 1'b1;
    @(negedge mclk);
    exc_return = 1'b0;
    mode(1'b0, 1'b0, 1'b0, 2'h0);
    ctrl_we = 1'b1;
    ctrl_wdata = 2'h2;
    sp_we = 1'b1;
    sp_wdata = 32'h0000_1005;
    @(negedge mclk);
    ctrl_we = 1'b0;
    sp_we = 1'b0;
    mode(1'b0, 1'b0, 1'b0, 2'h2);
    chk("main_stack_pointer_r", 32'h0000_1004, main_stack_pointer_r);
    chk("process_stack_pointer_r", 32'h1234_5678, process_stack_pointer_r);
    chk("sp_active_r", 32'h0000_1004, sp_active_r);
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    t_reset();
  endtask

  task automatic t_decode();
    logic [15:0] hw [5] = '{16'he800, 16'hf000, 16'hf800, 16'he000, 16'h4600};
    for (int i = 0; i < 5; i++) begin
      instr_word = {16'h0, hw[i]};
      @(negedge mclk);
      chk("instr_wide_r", (i < 3) ? 32'h1 : 32'h0, {31'h0, instr_wide_r});
    end
  endtask

  task automatic t_band();
    mem_req = 1'b1;
    mem_addr = 32'h2200_0084;
    @(negedge mclk);
    chk("bb_hit_r", 32'h1, {31'h0, bb_hit_r});
    chk("bb_word_addr_r", 32'h2000_0004, bb_word_addr_r);
    chk("bb_bit_r", 32'h1, {27'h0, bb_bit_r});
    mem_addr = 32'h23ff_fffc;
    @(negedge mclk);
    chk("bb_hit_r", 32'h1, {31'h0, bb_hit_r});
    chk("bb_word_addr_r", 32'h200f_fffc, bb_word_addr_r);
    chk("bb_bit_r", 32'h1f, {27'h0, bb_bit_r});
    mem_addr = 32'h2400_0000;
    @(negedge mclk);
    mem_req = 1'b0;
    chk("bb_hit_r", 32'h0, {31'h0, bb_hit_r});
    chk("bb_word_addr_r", 32'h200f_fffc, bb_word_addr_r);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    t_reset();
    t_user();
    t_fault();
    t_exc();
    t_nest();
    t_decode();
    t_band();
    summarize();
  end

  initial begin
    #5000;
    bad_count++;
    summarize();
  end
endmodule
